// ===== rtl/usr_pkg.sv
// Constants for the eight-stage universal shift register
package usr_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STEP = 5'h04;
    localparam logic [4:0] OFF_DIV = 5'h08;
    localparam logic [4:0] OFF_STATUS = 5'h0c;
    localparam logic [4:0] OFF_PORT_IN = 5'h10;
    localparam int CTRL_MSEL_LO = 0;
    localparam int CTRL_MSEL_HI = 1;
    localparam int CTRL_GATE_A = 2;
    localparam int CTRL_GATE_B = 3;
    localparam int CTRL_SER_R = 4;
    localparam int CTRL_SER_L = 5;
    localparam int CTRL_RUN = 6;
    localparam logic [6:0] CTRL_RESET = 7'h0c;
    localparam int DIV_W = 16;
    localparam logic [15:0] DIV_RESET = 16'h0013;
    localparam int STAT_FIRST = 8;
    localparam int STAT_LAST = 9;
    localparam int STAT_OE = 10;
    localparam logic [1:0] MODE_HOLD = 2'h0;
    localparam logic [1:0] MODE_RIGHT = 2'h1;
    localparam logic [1:0] MODE_LEFT = 2'h2;
    localparam logic [1:0] MODE_LOAD = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : usr_pkg

// ===== rtl/usr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module usr_pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Change counts once second and third stages agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_out <= '0;
        end else begin
            level_out <= (s2_reg & s3_reg) | ((s2_reg ^ s3_reg) & level_out);
        end
    end
endmodule : usr_pin_sync

// ===== rtl/usr_shift_top.sv
// Eight-stage universal shift register with AXI4-Lite control
`timescale 1ns/100ps
module usr_shift_top #(
    parameter int STAGES = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [usr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [usr_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [STAGES-1:0] port_in,
    output logic [STAGES-1:0] port_out,
    output logic [STAGES-1:0] port_oe,
    output logic serial_first_out,
    output logic serial_last_out
);
    logic [6:0] ctrl_reg;
    logic [usr_pkg::DIV_W-1:0] div_reg;
    logic [usr_pkg::DIV_W-1:0] div_cnt_reg;
    logic tick_reg;
    logic step_reg;
    logic [STAGES-1:0] stage_reg;
    logic [STAGES-1:0] stage_next;
    logic [STAGES-1:0] port_sync;
    logic aw_held_reg;
    logic aw_held_next;
    logic w_held_reg;
    logic w_held_next;
    logic [usr_pkg::ADDR_W-1:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic bvalid_next;
    logic do_write;
    logic [usr_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [1:0] bresp_next;
    logic [31:0] rd_word;
    logic rd_hit;
    logic mode_select_low_bit;
    logic mode_select_high_bit;
    logic port_drive_gate_a;
    logic port_drive_gate_b;
    logic [1:0] mode;
    logic advance;

    assign mode_select_low_bit = ctrl_reg[usr_pkg::CTRL_MSEL_LO];
    assign mode_select_high_bit = ctrl_reg[usr_pkg::CTRL_MSEL_HI];
    assign port_drive_gate_a = ctrl_reg[usr_pkg::CTRL_GATE_A];
    assign port_drive_gate_b = ctrl_reg[usr_pkg::CTRL_GATE_B];
    assign mode = {mode_select_high_bit, mode_select_low_bit};
    assign advance = step_reg | (ctrl_reg[usr_pkg::CTRL_RUN] & tick_reg);

    usr_pin_sync #(
        .WIDTH(STAGES)
    ) u_port_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(port_in),
        .level_out(port_sync)
    );

    // Write channel: address and data taken in either order
    always_comb begin
        aw_held_next = aw_held_reg | (s_axi_awvalid & s_axi_awready);
        w_held_next = w_held_reg | (s_axi_wvalid & s_axi_wready);
        wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
        wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
        wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
        bvalid_next = s_axi_bvalid & ~s_axi_bready;
        do_write = 1'b0;
        if (aw_held_next && w_held_next && !s_axi_bvalid) begin
            do_write = 1'b1;
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
        end
        case (wr_addr)
            usr_pkg::OFF_CTRL, usr_pkg::OFF_STEP, usr_pkg::OFF_DIV,
            usr_pkg::OFF_STATUS, usr_pkg::OFF_PORT_IN: bresp_next = usr_pkg::RESP_OKAY;
            default: bresp_next = usr_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= usr_pkg::RESP_OKAY;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            s_axi_awready <= ~aw_held_next & ~bvalid_next;
            s_axi_wready <= ~w_held_next & ~bvalid_next;
            s_axi_bvalid <= bvalid_next;
            if (do_write) begin
                s_axi_bresp <= bresp_next;
            end
        end
    end

    // Control, divider and step registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= usr_pkg::CTRL_RESET;
            div_reg <= usr_pkg::DIV_RESET;
            step_reg <= 1'b0;
        end else begin
            step_reg <= 1'b0;
            if (do_write && wr_addr == usr_pkg::OFF_CTRL && wr_strb[0]) begin
                ctrl_reg <= wr_data[6:0];
            end
            if (do_write && wr_addr == usr_pkg::OFF_DIV) begin
                if (wr_strb[0]) begin
                    div_reg[7:0] <= wr_data[7:0];
                end
                if (wr_strb[1]) begin
                    div_reg[15:8] <= wr_data[15:8];
                end
            end
            if (do_write && wr_addr == usr_pkg::OFF_STEP && wr_strb[0]) begin
                step_reg <= wr_data[0];
            end
        end
    end

    // Free-running shift rate enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else if (div_cnt_reg >= div_reg) begin
            div_cnt_reg <= '0;
            tick_reg <= 1'b1;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
            tick_reg <= 1'b0;
        end
    end

    // Stage next value by mode
    always_comb begin
        stage_next = stage_reg;
        unique case (mode)
            usr_pkg::MODE_HOLD: stage_next = stage_reg;
            usr_pkg::MODE_RIGHT: stage_next = {stage_reg[STAGES-2:0], ctrl_reg[usr_pkg::CTRL_SER_R]};
            usr_pkg::MODE_LEFT: stage_next = {ctrl_reg[usr_pkg::CTRL_SER_L], stage_reg[STAGES-1:1]};
            usr_pkg::MODE_LOAD: stage_next = port_sync;
        endcase
    end

    // Stages clear without the clock and step only on an advance edge
    always_ff @(posedge aclk or negedge aresetn) begin
        if (!aresetn) begin
            stage_reg <= '0;
        end else if (advance) begin
            stage_reg <= stage_next;
        end
    end

    assign serial_first_out = stage_reg[0];
    assign serial_last_out = stage_reg[STAGES-1];
    assign port_out = stage_reg;

    // Port drive gating
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_oe <= '0;
        end else if (mode == usr_pkg::MODE_LOAD || port_drive_gate_a || port_drive_gate_b) begin
            port_oe <= '0;
        end else begin
            port_oe <= '1;
        end
    end

    // Read channel
    always_comb begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            usr_pkg::OFF_CTRL: rd_word[6:0] = ctrl_reg;
            usr_pkg::OFF_STEP: rd_word = 32'h0;
            usr_pkg::OFF_DIV: rd_word[15:0] = div_reg;
            usr_pkg::OFF_STATUS: begin
                rd_word[STAGES-1:0] = stage_reg;
                rd_word[usr_pkg::STAT_FIRST] = stage_reg[0];
                rd_word[usr_pkg::STAT_LAST] = stage_reg[STAGES-1];
                rd_word[usr_pkg::STAT_OE] = port_oe[0];
            end
            usr_pkg::OFF_PORT_IN: rd_word[STAGES-1:0] = port_sync;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= usr_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? usr_pkg::RESP_OKAY : usr_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Checks
    property p_load_capture;
        @(posedge aclk) disable iff (!aresetn)
        advance && mode == usr_pkg::MODE_LOAD |=> stage_reg == $past(port_sync)
            && serial_first_out == $past(port_sync[0]);
    endproperty
    a_load_capture: assert property (p_load_capture) else $error("Parallel load missed");

    property p_shift_right;
        @(posedge aclk) disable iff (!aresetn)
        advance && mode == usr_pkg::MODE_RIGHT |=> stage_reg ==
            {$past(stage_reg[STAGES-2:0]), $past(ctrl_reg[usr_pkg::CTRL_SER_R])};
    endproperty
    a_shift_right: assert property (p_shift_right) else $error("Right shift wrong");

    property p_shift_left;
        @(posedge aclk) disable iff (!aresetn)
        advance && mode == usr_pkg::MODE_LEFT |=> stage_reg ==
            {$past(ctrl_reg[usr_pkg::CTRL_SER_L]), $past(stage_reg[STAGES-1:1])};
    endproperty
    a_shift_left: assert property (p_shift_left) else $error("Left shift wrong");

    property p_hold;
        @(posedge aclk) disable iff (!aresetn)
        !advance || mode == usr_pkg::MODE_HOLD |=> $stable(stage_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("Stages moved without a shift");

    property p_reset_clear;
        @(posedge aclk) !aresetn |-> stage_reg == '0 && !serial_first_out && !serial_last_out;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Reset did not clear");

    property p_load_float;
        @(posedge aclk) disable iff (!aresetn)
        mode == usr_pkg::MODE_LOAD |=> port_oe == '0;
    endproperty
    a_load_float: assert property (p_load_float) else $error("Port driven in load");

    property p_gate_float;
        @(posedge aclk) disable iff (!aresetn)
        port_drive_gate_a || port_drive_gate_b |=> port_oe == '0;
    endproperty
    a_gate_float: assert property (p_gate_float) else $error("Port driven while gated");

    property p_drive;
        @(posedge aclk) disable iff (!aresetn)
        !port_drive_gate_a && !port_drive_gate_b && mode != usr_pkg::MODE_LOAD
            |=> port_oe == '1 && port_out == stage_reg;
    endproperty
    a_drive: assert property (p_drive) else $error("Port not driven");

    property p_gated_shift;
        @(posedge aclk) disable iff (!aresetn)
        (port_drive_gate_a || port_drive_gate_b) && advance && mode == usr_pkg::MODE_RIGHT
            |=> stage_reg[STAGES-1:1] == $past(stage_reg[STAGES-2:0]);
    endproperty
    a_gated_shift: assert property (p_gated_shift) else $error("Gating stopped shift");

    property p_serial_ends;
        @(posedge aclk) disable iff (!aresetn)
        advance && mode == usr_pkg::MODE_LEFT
            |=> serial_last_out == $past(ctrl_reg[usr_pkg::CTRL_SER_L])
            && serial_first_out == $past(stage_reg[1]);
    endproperty
    a_serial_ends: assert property (p_serial_ends) else $error("Serial output stale");

    c_load: cover property (@(posedge aclk) disable iff (!aresetn)
        advance && mode == usr_pkg::MODE_LOAD);
    c_right_gated: cover property (@(posedge aclk) disable iff (!aresetn)
        advance && mode == usr_pkg::MODE_RIGHT && port_drive_gate_a);
    c_left: cover property (@(posedge aclk) disable iff (!aresetn)
        advance && mode == usr_pkg::MODE_LEFT ##1 port_oe == '1);
endmodule : usr_shift_top

// ===== bench/usr_pin_model.sv
// Far-side bus logic model for the parallel port
`timescale 1ns/100ps
module usr_pin_model #(
    parameter int W = 8
) (
    input wire logic aclk,
    input wire logic [W-1:0] port_out,
    input wire logic [W-1:0] port_oe,
    input wire logic host_en,
    input wire logic [W-1:0] host_val,
    output logic [W-1:0] port_in
);
    logic [W-1:0] last_reg = '0;
    // Remember only the last level that someone actually drove
    always_ff @(posedge aclk) begin
        for (int i = 0; i < W; i++) begin
            if (port_oe[i] || host_en) begin
                last_reg[i] <= port_in[i];
            end
        end
    end
    // Wire level; a released line shows the inverse of its last level
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (port_oe[i]) begin
                port_in[i] = port_out[i];
            end else if (host_en) begin
                port_in[i] = host_val[i];
            end else begin
                port_in[i] = ~last_reg[i];
            end
        end
    end
endmodule : usr_pin_model

// ===== bench/usr_shift_top_tb.sv
// Self-checking bench for the shift register block
`timescale 1ns/100ps
module usr_shift_top_tb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sf, sl, host_en;
    logic [4:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] pin, pout, poe, host_val;
    int n_mismatch = 0;
    int n_checks = 0;

    usr_shift_top #(.STAGES(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port_in(pin),
        .port_out(pout), .port_oe(poe), .serial_first_out(sf), .serial_last_out(sl));
    usr_pin_model #(.W(8)) i_host (.aclk(aclk), .port_out(pout), .port_oe(poe),
        .host_en(host_en), .host_val(host_val), .port_in(pin));

    always #25 aclk = ~aclk;

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic timeout(input int n);
        if (n >= 50) begin
            n_mismatch++;
            test_done();
        end
    endtask : timeout

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        int n;
        logic aw, w;
        aw = 1;
        w = 1;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while ((aw || w) && n < 50) begin
            @(posedge aclk);
            n++;
            if (aw && awready) begin
                aw = 0;
                awvalid <= 0;
            end
            if (w && wready) begin
                w = 0;
                wvalid <= 0;
            end
        end
        do begin
            @(posedge aclk);
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        rsp = bresp;
        bready <= 0;
        timeout(n);
    endtask : wr

    task automatic rdr(input logic [4:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge aclk);
            n++;
        end while (arready !== 1'b1 && n < 50);
        arvalid <= 0;
        do begin
            @(posedge aclk);
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        rd = rdata;
        rsp = rresp;
        rready <= 0;
        timeout(n);
    endtask : rdr

    task automatic step();
        wr(usr_pkg::OFF_STEP, 32'h1);
        repeat (3) @(posedge aclk);
    endtask : step

    task automatic sc_reset_values();
        rdr(usr_pkg::OFF_CTRL);
        check(rd[6:0], 32'h0c);
        rdr(usr_pkg::OFF_DIV);
        check(rd[15:0], 32'h13);
        check(poe, 32'h0);
        rdr(5'h14);
        check(rsp, usr_pkg::RESP_SLVERR);
        wr(5'h14, 32'h3);
        check(rsp, usr_pkg::RESP_SLVERR);
    endtask : sc_reset_values

    task automatic sc_load();
        host_en <= 1;
        host_val <= 8'ha5;
        wr(usr_pkg::OFF_CTRL, 32'h03);
        repeat (6) @(posedge aclk);
        check(poe, 32'h0);
        rdr(usr_pkg::OFF_PORT_IN);
        check(rd[7:0], 32'ha5);
        step();
        rdr(usr_pkg::OFF_STATUS);
        check(rd[10:0], 32'h3a5);
        check({sl, sf}, 32'h3);
        host_en <= 0;
    endtask : sc_load

    task automatic sc_shift();
        wr(usr_pkg::OFF_CTRL, 32'h11);
        repeat (2) @(posedge aclk);
        step();
        check(pout, 32'h4b);
        check(poe, 32'hff);
        check(pin, 32'h4b);
        wr(usr_pkg::OFF_CTRL, 32'h06);
        step();
        check(poe, 32'h0);
        check(pout, 32'h25);
        check({sl, sf}, 32'h1);
        wr(usr_pkg::OFF_CTRL, 32'h08);
        step();
        step();
        check(poe, 32'h0);
        check(pout, 32'h25);
    endtask : sc_shift

    task automatic sc_async_clear();
        aresetn <= 0;
        #5;
        check({sl, sf, pout}, 32'h0);
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rdr(usr_pkg::OFF_CTRL);
        check(rd[6:0], 32'h0c);
    endtask : sc_async_clear

    task automatic sc_run();
        host_en <= 1;
        host_val <= 8'h81;
        wr(usr_pkg::OFF_CTRL, 32'h03);
        repeat (6) @(posedge aclk);
        step();
        host_en <= 0;
        wr(usr_pkg::OFF_DIV, 32'h0);
        rdr(usr_pkg::OFF_DIV);
        check(rd[15:0], 32'h0);
        wr(usr_pkg::OFF_CTRL, 32'h45);
        repeat (10) @(posedge aclk);
        wr(usr_pkg::OFF_CTRL, 32'h00);
        check(pout, 32'h0);
    endtask : sc_run

    initial begin
        aclk = 0;
        aresetn = 0;
        {awvalid, wvalid, bready, arvalid, rready, host_en} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        host_val = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        sc_reset_values();
        sc_load();
        sc_shift();
        sc_async_clear();
        sc_run();
        test_done();
    end
endmodule : usr_shift_top_tb
